// [core/spwm_channel.sv]
// Functional notes
// - Timer clears on the increment after count equals period limit
// - Output goes high at period start unless duty is zero
// - Period match copies written duty into active buffer
// - Duty is 10 bits: msb byte plus control bits 5:4
// - Duty writes accepted anytime, effective only at next match
// - Active duty buffer is read-only while PWM mode is active
// - Duty is double buffered in active byte plus 2-bit latch
// - Time base is count plus clock quarter or prescaler bits
// - Output goes low when time base equals buffered duty
// - Period is (limit+1) times 4 clocks times prescale
// - No postscaler affects PWM timing
// - High time is duty times clock times prescale
// - Two-bit select field picks one of three timers
// - Resolution reaches 10 bits only with limit 255
// - Duty beyond period never clears, output stays unchanged
// - Sleep freezes timer and state, pin keeps its level
// - Prescale ratios are 1, 4 and 16
// - Zero control register releases the output pin
// - Reset clears registers except period limit (FF) and pin direction (1), and sets pin to input
module spwm_channel
	import spwm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        sleep,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             pwm_output_pin,
	output logic             pwm_output_pin_oe_n,
	output logic             pwm_active
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]            channel_control_reg;
	logic [7:0]            duty_msb_write_reg;
	logic [7:0]            duty_active_buffer;
	logic [1:0]            duty_lsb_latch;
	logic [1:0]            timer_select_field;
	logic                  pin_direction_bit;
	logic [7:0]            timer_control_reg [NUM_TIMERS];
	logic [7:0]            period_limit_reg  [NUM_TIMERS];
	logic [7:0]            period_timer_count[NUM_TIMERS];
	logic [1:0]            tsub              [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] tmatch;
	logic [NUM_TIMERS-1:0] timer_match_flag;
	logic [NUM_TIMERS-1:0] count_wr;
	logic [NUM_TIMERS-1:0] flag_clr;
	logic                  pwm_level;

	logic        wr_en;
	logic        rd_en;
	logic        pwm_mode;
	logic [1:0]  duty_lsb_bits;
	logic [9:0]  time_base;
	logic [9:0]  active_duty;
	logic [9:0]  written_duty;
	logic        sel_match;
	logic [1:0]  tidx;
	logic [11:0] toff;
	logic        tsel_ok;
	logic        mapped;
	logic [31:0] next_prdata;

	// APB access strobes; slave answers in the first access cycle
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;
	assign pwm_mode      = (channel_control_reg[CTRL_MODE_HI:0] & MODE_PWM_MASK) == MODE_PWM_A;
	assign duty_lsb_bits = channel_control_reg[CTRL_DLSB_LO+1:CTRL_DLSB_LO];
	assign written_duty  = {duty_msb_write_reg, duty_lsb_bits};
	assign active_duty   = {duty_active_buffer, duty_lsb_latch};

	// Timer window decode
	always_comb begin
		tidx    = 2'h0;
		toff    = 12'h000;
		tsel_ok = 1'b0;
		if (paddr >= ADDR_TIMER_BASE && paddr < ADDR_TIMER_BASE + TIMER_STRIDE) begin
			tidx    = 2'h0;
			toff    = paddr - ADDR_TIMER_BASE;
			tsel_ok = 1'b1;
		end else if (paddr >= ADDR_TIMER_BASE + TIMER_STRIDE &&
		             paddr < ADDR_TIMER_BASE + 12'h002 * TIMER_STRIDE) begin
			tidx    = 2'h1;
			toff    = paddr - ADDR_TIMER_BASE - TIMER_STRIDE;
			tsel_ok = 1'b1;
		end else if (paddr >= ADDR_TIMER_BASE + 12'h002 * TIMER_STRIDE &&
		             paddr < ADDR_TIMER_BASE + 12'h003 * TIMER_STRIDE) begin
			tidx    = 2'h2;
			toff    = paddr - ADDR_TIMER_BASE - 12'h002 * TIMER_STRIDE;
			tsel_ok = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Shared timers
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
			assign count_wr[g] = wr_en && tsel_ok && tidx == 2'(g) && toff == TOFF_COUNT;
			assign flag_clr[g] = wr_en && tsel_ok && tidx == 2'(g) && toff == TOFF_FLAG && !pwdata[0];
			// Only prescaler and period limit shape timing; no postscaler
			spwm_timer u_tmr (
				.clk       (clk),
				.nrst      (nrst),
				.sleep     (sleep),
				.run       (timer_control_reg[g][TCON_RUN_BIT]),
				.prescale  (timer_control_reg[g][1:0]),
				.period    (period_limit_reg[g]),
				.count_wr  (count_wr[g]),
				.flag_clr  (flag_clr[g]),
				.count     (period_timer_count[g]),
				.sub       (tsub[g]),
				.match_evt (tmatch[g]),
				.flag      (timer_match_flag[g])
			);

			// Timer control and period registers
			always_ff @(posedge clk) begin
				if (!nrst) begin
					timer_control_reg[g] <= RST_TCON;
					period_limit_reg[g]  <= RST_PERIOD;
				end else if (wr_en && tsel_ok && tidx == 2'(g)) begin
					if (toff == TOFF_CONTROL)
						timer_control_reg[g] <= pwdata[7:0];
					if (toff == TOFF_PERIOD)
						period_limit_reg[g] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// Selected timer source; select code 3 is treated as timer 0
	always_comb begin
		case (timer_select_field)
			2'h1:    begin time_base = {period_timer_count[1], tsub[1]}; sel_match = tmatch[1]; end
			2'h2:    begin time_base = {period_timer_count[2], tsub[2]}; sel_match = tmatch[2]; end
			default: begin time_base = {period_timer_count[0], tsub[0]}; sel_match = tmatch[0]; end
		endcase
	end

	// ------------------------------------------------------------
	// Channel software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			channel_control_reg <= RST_CONTROL;
			duty_msb_write_reg  <= RST_DUTY;
			timer_select_field  <= RST_TSEL;
			pin_direction_bit   <= RST_DIR;
		end else if (wr_en) begin
			if (paddr == ADDR_CHANNEL_CONTROL)
				channel_control_reg <= pwdata[7:0];
			if (paddr == ADDR_DUTY_MSB_WRITE)
				duty_msb_write_reg <= pwdata[7:0];
			if (paddr == ADDR_TIMER_SELECT)
				timer_select_field <= pwdata[1:0];
			if (paddr == ADDR_PIN_CONTROL)
				pin_direction_bit <= pwdata[0];
		end
	end

	// Active duty buffer: loads at match, writable only outside PWM
	always_ff @(posedge clk) begin
		if (!nrst) begin
			duty_active_buffer <= RST_DUTY;
			duty_lsb_latch     <= 2'h0;
		end else if (pwm_mode && sel_match) begin
			duty_active_buffer <= written_duty[9:2];
			duty_lsb_latch     <= written_duty[1:0];
		end else if (wr_en && !pwm_mode && paddr == ADDR_DUTY_ACTIVE) begin
			duty_active_buffer <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Waveform
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst)
			pwm_level <= 1'b0;
		else if (!pwm_mode)
			pwm_level <= 1'b0;
		else if (sel_match)
			pwm_level <= (written_duty != 10'h000);
		else if (time_base == active_duty)
			pwm_level <= 1'b0;
		else if (sleep)
			pwm_level <= pwm_level;
	end

	// Pin drive and release; pin drops as the time base reaches the duty,
	// so the high time is exactly duty steps and not one clock longer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwm_output_pin      <= 1'b0;
			pwm_output_pin_oe_n <= 1'b1;
			pwm_active          <= 1'b0;
		end else begin
			pwm_output_pin      <= pwm_level && (time_base != active_duty);
			pwm_output_pin_oe_n <= !(pwm_mode && !pin_direction_bit);
			pwm_active          <= pwm_mode;
		end
	end

	// ------------------------------------------------------------
	// APB read path and answer
	// ------------------------------------------------------------
	always_comb begin
		next_prdata = 32'h0000_0000;
		mapped      = 1'b1;
		if (tsel_ok) begin
			case (toff)
				TOFF_CONTROL: next_prdata[7:0] = timer_control_reg[tidx];
				TOFF_PERIOD:  next_prdata[7:0] = period_limit_reg[tidx];
				TOFF_COUNT:   next_prdata[7:0] = period_timer_count[tidx];
				TOFF_FLAG:    next_prdata[0]   = timer_match_flag[tidx];
				default:      mapped           = 1'b0;
			endcase
		end else if (paddr == ADDR_CHANNEL_CONTROL)
			next_prdata[7:0] = channel_control_reg;
		else if (paddr == ADDR_DUTY_MSB_WRITE)
			next_prdata[7:0] = duty_msb_write_reg;
		else if (paddr == ADDR_DUTY_ACTIVE)
			next_prdata[9:0] = active_duty;
		else if (paddr == ADDR_TIMER_SELECT)
			next_prdata[1:0] = timer_select_field;
		else if (paddr == ADDR_PIN_CONTROL)
			next_prdata[0] = pin_direction_bit;
		else if (paddr == ADDR_STATUS)
			next_prdata[1:0] = {pwm_level, pwm_mode};
		else
			mapped = 1'b0;
	end

	// Data captured in setup, ready in the access cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (rd_en)
				prdata <= next_prdata;
		end
	end
endmodule

// [core/spwm_timer.sv]
// One shared 8-bit period timer with 1/4/16 prescaler
module spwm_timer
	import spwm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sleep,
	input  wire logic       run,
	input  wire logic [1:0] prescale,
	input  wire logic [7:0] period,
	input  wire logic       count_wr,
	input  wire logic       flag_clr,
	output logic      [7:0] count,
	output logic      [1:0] sub,
	output logic            match_evt,
	output logic            flag
);
	logic [3:0] pre;
	logic [5:0] pre_full;
	logic       tick;
	logic       wrap;

	// --------------------------------------------------------
	// Increment strobe: one per 4 clocks times prescale
	// --------------------------------------------------------
	// Decoded from the full counter so 1:16 strobes once, not four times
	always_comb begin
		case (prescale)
			PRESCALE_1: wrap = (pre_full[1:0] == 2'h3);
			PRESCALE_4: wrap = (pre_full[3:0] == 4'hF);
			default:    wrap = (pre_full == 6'h3F);
		endcase
	end
	// Sub-count bits: clock quarter at 1:1, prescaler bits above
	always_comb begin
		case (prescale)
			PRESCALE_1: sub = pre[1:0];
			PRESCALE_4: sub = pre[3:2];
			default:    sub = pre[3:2];
		endcase
	end
	assign tick      = run && !sleep && wrap;
	assign match_evt = tick && (count == period);

	// Prescaler and quarter counter; 1:16 uses the top four bits
	assign pre = (prescale == PRESCALE_1) ? {2'h0, pre_full[1:0]} :
	             (prescale == PRESCALE_4) ? pre_full[3:0] : pre_full[5:2];
	always_ff @(posedge clk) begin
		if (!nrst)
			pre_full <= 6'h00;
		else if (run && !sleep)
			pre_full <= (prescale == PRESCALE_1 && pre_full[1:0] == 2'h3) ? 6'h00 :
			            (prescale == PRESCALE_4 && pre_full[3:0] == 4'hF) ? 6'h00 :
			            pre_full + 6'h01;
	end

	// Timer count clears on the match increment, the one taken while count equals period
	always_ff @(posedge clk) begin
		if (!nrst)
			count <= 8'h00;
		else if (count_wr)
			count <= 8'h00;
		else if (match_evt)
			count <= 8'h00;
		else if (tick)
			count <= count + 8'h01;
	end

	// Match flag: set wins over clear
	always_ff @(posedge clk) begin
		if (!nrst)
			flag <= 1'b0;
		else if (match_evt)
			flag <= 1'b1;
		else if (flag_clr)
			flag <= 1'b0;
	end
endmodule

// [include/spwm_pkg.sv]
package spwm_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CHANNEL_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_DUTY_MSB_WRITE  = 12'h004;
	localparam logic [11:0] ADDR_DUTY_ACTIVE     = 12'h008;
	localparam logic [11:0] ADDR_TIMER_SELECT    = 12'h00C;
	localparam logic [11:0] ADDR_PIN_CONTROL     = 12'h010;
	localparam logic [11:0] ADDR_STATUS          = 12'h014;
	localparam logic [11:0] ADDR_TIMER_BASE      = 12'h020;
	localparam logic [11:0] TIMER_STRIDE         = 12'h010;
	localparam logic [11:0] TOFF_CONTROL         = 12'h000;
	localparam logic [11:0] TOFF_PERIOD          = 12'h004;
	localparam logic [11:0] TOFF_COUNT           = 12'h008;
	localparam logic [11:0] TOFF_FLAG            = 12'h00C;

	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int          CTRL_DLSB_LO     = 4;
	localparam int          CTRL_MODE_HI     = 3;
	localparam logic [3:0]  MODE_PWM_A       = 4'hC;
	localparam logic [3:0]  MODE_PWM_MASK    = 4'hC;
	localparam int          TCON_RUN_BIT     = 2;
	localparam logic [1:0]  PRESCALE_1       = 2'h0;
	localparam logic [1:0]  PRESCALE_4       = 2'h1;
	localparam int          NUM_TIMERS       = 3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_CONTROL      = 8'h00;
	localparam logic [7:0]  RST_DUTY         = 8'h00;
	localparam logic [7:0]  RST_PERIOD       = 8'hFF;
	localparam logic [7:0]  RST_TCON         = 8'h00;
	localparam logic [1:0]  RST_TSEL         = 2'h0;
	localparam logic        RST_DIR          = 1'b1;
endpackage

// [test/spwm_channel_assertions.sv]
module spwm_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sleep,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pwm_output_pin,
	input wire logic pwm_output_pin_oe_n,
	input wire logic pwm_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// --------------------------
	// Pin ownership and freeze
	// --------------------------
	rst_state_a: assert property (disable iff (1'b0) !nrst |=> pwm_output_pin_oe_n && !pwm_active)
		else $error("pin not released in reset");
	oe_mode_a: assert property (!pwm_active [*2] |-> pwm_output_pin_oe_n)
		else $error("pin driven outside pwm mode");
	idle_pin_low_a: assert property (!pwm_active [*3] |-> !pwm_output_pin)
		else $error("pin level high outside pwm mode");
	mode_off_release_a: assert property ($fell(pwm_active) |-> ##[0:2] pwm_output_pin_oe_n)
		else $error("pin kept after mode cleared");
	sleep_hold_a: assert property (sleep [*3] |-> $stable(pwm_output_pin))
		else $error("pin moved during sleep");
	// --------------------------
	// Register bus handshake
	// --------------------------
	wait_free_a: assert property (psel && !penable |=> pready)
		else $error("access phase without ready");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error without ready");
endmodule

bind spwm_channel spwm_chk u_chk (.clk(clk), .nrst(nrst), .sleep(sleep), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .pwm_output_pin(pwm_output_pin),
	.pwm_output_pin_oe_n(pwm_output_pin_oe_n), .pwm_active(pwm_active));

// [test/spwm_load.sv]
module spwm_load (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        pin,
	input  wire logic        oe_n,
	output logic             level,
	output logic      [15:0] period,
	output logic      [15:0] high,
	output logic      [15:0] edges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        last;
	logic [15:0] since;
	logic [15:0] hcnt;
	// Load pulls a released pin low
	assign level = oe_n ? 1'b0 : pin;
	// Spacing of rising edges and width of each high pulse
	always_ff @(posedge clk) begin
		last  <= level;
		since <= (level && !last) ? 16'h0001 : since + 16'h0001;
		hcnt  <= (level && last) ? hcnt + 16'h0001 : 16'h0001;
		if (!nrst) begin
			edges <= 16'h0000;
		end else if (level && !last) begin
			period <= since;
			edges  <= edges + 16'h0001;
		end
		if (!level && last)
			high <= hcnt;
	end
endmodule

// [test/standard_pwm_channel_tb.sv]
module standard_pwm_channel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spwm_pkg::*;
	localparam logic [11:0] T1 = ADDR_TIMER_BASE + TIMER_STRIDE;
	logic        clk;
	logic        nrst;
	logic        sleep;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready;
	logic        pslverr;
	logic        e;
	logic        pin;
	logic        oe_n;
	logic        act;
	logic        level;
	logic [15:0] period;
	logic [15:0] high;
	logic [15:0] edges;
	int          fail_count;
	int          n_tests;

	spwm_channel u_dut (.clk(clk), .nrst(nrst), .sleep(sleep), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_output_pin(pin), .pwm_output_pin_oe_n(oe_n), .pwm_active(act));
	spwm_load u_load (.clk(clk), .nrst(nrst), .pin(pin), .oe_n(oe_n), .level(level),
		.period(period), .high(high), .edges(edges));

	// -----------------
	// Helpers
	// -----------------
	task automatic ck(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// One APB transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			fail_count++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		ck(q, x);
	endtask
	task automatic wait_edges(input int k);
		int n;
		int e0;
		n = 0;
		e0 = edges;
		while (edges < e0 + k && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
			fail_count++;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// -----------------
	// Scenarios
	// -----------------
	task automatic t_reset();
		rd(ADDR_CHANNEL_CONTROL, 32'h0000_0000);
		rd(T1 + TOFF_PERIOD, 32'h0000_00FF);
		rd(ADDR_PIN_CONTROL, 32'h0000_0001);
		ck(oe_n, 1'b1);
		rd(12'hFFC, 32'h0000_0000);
		ck(e, 1'b1);
		$display("reset test done");
	endtask
	// Duty 6: msb byte 1, low bits 2; timer 1 with limit 3
	task automatic t_setup();
		int n;
		n = 0;
		wr(ADDR_PIN_CONTROL, 32'h0000_0001);
		wr(T1 + TOFF_PERIOD, 32'h0000_0003);
		wr(ADDR_CHANNEL_CONTROL, 32'h0000_002C);
		wr(ADDR_DUTY_MSB_WRITE, 32'h0000_0001);
		wr(ADDR_TIMER_SELECT, 32'h0000_0001);
		wr(T1 + TOFF_FLAG, 32'h0000_0000);
		wr(T1 + TOFF_CONTROL, 32'h0000_0004);
		ck(oe_n, 1'b1);
		q = 32'h0000_0000;
		while (q[0] !== 1'b1 && n < 40) begin
			apb(1'b0, T1 + TOFF_FLAG, 32'h0000_0000);
			n++;
		end
		ck(q, 32'h0000_0001);
		wr(ADDR_PIN_CONTROL, 32'h0000_0000);
		wait_edges(3);
		ck(oe_n, 1'b0);
		ck(act, 1'b1);
		ck(period, 32'd16);
		ck(high, 32'd6);
		rd(ADDR_DUTY_ACTIVE, 32'h0000_0006);
		$display("setup test done");
	endtask
	task automatic t_prescale();
		logic [1:0] code [3];
		int         ratio [3];
		code  = '{PRESCALE_1, PRESCALE_4, 2'h2};
		ratio = '{1, 4, 16};
		for (int i = 0; i < 3; i++) begin
			wr(T1 + TOFF_CONTROL, 32'h0000_0004 | 32'(code[i]));
			wait_edges(3);
			ck(period, 32'(16 * ratio[i]));
			ck(high, 32'(6 * ratio[i]));
		end
		wr(T1 + TOFF_CONTROL, 32'h0000_0004);
		$display("prescale test done");
	endtask
	task automatic t_duty();
		wait_edges(1);
		wr(ADDR_DUTY_MSB_WRITE, 32'h0000_0002);
		rd(ADDR_DUTY_ACTIVE, 32'h0000_0006);
		wait_edges(1);
		wr(ADDR_DUTY_ACTIVE, 32'h0000_03FF);
		rd(ADDR_DUTY_ACTIVE, 32'h0000_000A);
		wait_edges(2);
		rd(ADDR_DUTY_ACTIVE, 32'h0000_000A);
		ck(high, 32'd10);
		$display("duty test done");
	endtask
	task automatic t_extreme();
		int e1;
		wr(ADDR_CHANNEL_CONTROL, 32'h0000_000C);
		wr(ADDR_DUTY_MSB_WRITE, 32'h0000_0000);
		repeat (40) @(posedge clk);
		e1 = edges;
		repeat (40) @(posedge clk);
		ck(edges, e1);
		ck(level, 1'b0);
		rd(ADDR_STATUS, 32'h0000_0001);
		wr(ADDR_DUTY_MSB_WRITE, 32'h0000_0008);
		repeat (40) @(posedge clk);
		e1 = edges;
		repeat (40) @(posedge clk);
		ck(edges, e1);
		ck(level, 1'b1);
		rd(ADDR_STATUS, 32'h0000_0003);
		wr(ADDR_CHANNEL_CONTROL, 32'h0000_002C);
		wr(ADDR_DUTY_MSB_WRITE, 32'h0000_0001);
		wait_edges(3);
		$display("extreme duty test done");
	endtask
	task automatic t_sleep();
		logic        l;
		logic [31:0] c;
		wait_edges(1);
		repeat (2) @(posedge clk);
		sleep <= 1'b1;
		repeat (4) @(posedge clk);
		l = level;
		apb(1'b0, T1 + TOFF_COUNT, 32'h0000_0000);
		c = q;
		repeat (20) @(posedge clk);
		ck(level, l);
		rd(T1 + TOFF_COUNT, c);
		sleep <= 1'b0;
		wait_edges(2);
		ck(period, 32'd16);
		$display("sleep test done");
	endtask
	task automatic t_release();
		wr(ADDR_CHANNEL_CONTROL, 32'h0000_0000);
		repeat (3) @(posedge clk);
		ck(oe_n, 1'b1);
		ck(act, 1'b0);
		ck(level, 1'b0);
		$display("release test done");
	endtask

	// -----------------
	// Clock, run and watchdog
	// -----------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	initial begin
		fail_count = 0;
		n_tests    = 0;
		nrst    <= 1'b0;
		sleep   <= 1'b0;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 12'h000;
		pwdata  <= 32'h0000_0000;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset();
		t_setup();
		t_prescale();
		t_duty();
		t_extreme();
		t_sleep();
		t_release();
		finish_test();
	end
endmodule
